// [hw/vwvs_top.sv]
// Vertical window select for the second output window, with AXI4-Lite registers
// Function
// - Report the delay from the falling edge of the horizontal reference to the window's active flag in bits [11:1].
// - Use the nine-bit first-line value (reset 17) as the first active line of the window in each field.
// - Use the nine-bit input line count (reset 500) as the span from first to last window line.
// - Clamp the span to the standard's line count when first line plus span exceeds it.
// - With temporal decimation on, output only the kept-frame count of frames per 3000; otherwise output all.
// - Field disable bits: 11 off, 10 odd fields only, 01 even fields only, 00 both fields.
// - When output count is below the span (input count, clamped), drop lines so exactly the output count is delivered per field.
`timescale 1ns/10ps
module vwvs_top #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // AXI4-Lite slave
  input wire logic [vwvs_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [vwvs_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Decoded video from the front end, same clock
  input wire logic horizontal_reference_i,
  input wire logic vref_i,
  input wire logic field_odd_i,
  input wire logic pix_valid_i,
  input wire logic [vwvs_pkg::PIX_W-1:0] pix_i,
  // Windowed stream to capture logic
  output logic win_active_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [vwvs_pkg::PIX_W-1:0] out_pix_o,
  output logic out_sol_o,
  output logic out_sof_o
);
  localparam int unsigned SW = vwvs_pkg::PIX_W + 2;

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("vwvs_top: FIFO_DEPTH must be at least 2");
    end
  end

  typedef struct packed {
    // Bus slave
    logic awready;
    logic wready;
    logic aw_have;
    logic [9:0] aw_idx;
    logic w_have;
    logic [11:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [11:0] rdata;
    // Software registers
    logic [8:0] first_line;
    logic [11:0] input_lines;
    logic [8:0] output_lines;
    logic [11:0] kept_frames;
    logic std_525;
    // Video tracking
    logic horizontal_reference_prev;
    logic vref_prev;
    logic field_odd;
    logic field_on;
    logic frame_keep;
    logic [12:0] frame_acc;
    logic [9:0] line_no;
    logic [9:0] line_acc;
    logic [8:0] delivered;
    logic [8:0] last_delivered;
    logic line_keep;
    logic sol_pend;
    logic sof_pend;
    logic [10:0] meas_cnt;
    logic meas_arm;
    logic [10:0] active_offset;
    logic overflow;
    // Stream into FIFO
    logic push;
    logic [SW-1:0] push_data;
    logic active;
  } vwvs_top_s;

  vwvs_top_s st_q;
  vwvs_top_s st_d;

  vwvs_stream_if #(.WIDTH(SW)) fifo_in ();
  vwvs_stream_if #(.WIDTH(SW)) fifo_out ();

  vwvs_fifo #(
    .WIDTH(SW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr(fifo_in.snk),
    .rd(fifo_out.src)
  );

  assign fifo_in.valid = st_q.push;
  assign fifo_in.data = st_q.push_data;
  assign fifo_out.ready = out_ready_i;
  assign out_valid_o = fifo_out.valid;
  assign out_pix_o = fifo_out.data[vwvs_pkg::PIX_W-1:0];
  assign out_sol_o = fifo_out.data[vwvs_pkg::PIX_W];
  assign out_sof_o = fifo_out.data[vwvs_pkg::PIX_W+1];
  assign win_active_o = st_q.active;
  assign s_axi_awready_o = st_q.awready;
  assign s_axi_wready_o = st_q.wready;
  assign s_axi_bvalid_o = st_q.bvalid;
  assign s_axi_bresp_o = st_q.bresp;
  assign s_axi_arready_o = st_q.arready;
  assign s_axi_rvalid_o = st_q.rvalid;
  assign s_axi_rresp_o = st_q.rresp;
  assign s_axi_rdata_o = {20'h00000, st_q.rdata};

  // Window geometry derived from the registers
  logic [9:0] max_lines;
  logic [9:0] win_end;
  logic [10:0] raw_end;
  logic [8:0] span;
  logic [8:0] out_eff;
  logic in_window;
  logic field_enable;
  logic horizontal_reference_rise;
  logic horizontal_reference_fall;
  logic vref_rise;
  logic pix_active;
  logic keep_new;
  logic line_keep_now;
  logic [9:0] line_next;
  logic [10:0] line_acc_sum;
  logic [13:0] frame_sum;

  always_comb begin
    max_lines = st_q.std_525 ? vwvs_pkg::MAX_LINES_525 : vwvs_pkg::MAX_LINES_625;
    raw_end = {2'h0, st_q.first_line} + {2'h0, st_q.input_lines[8:0]};
    // Past the last line of the standard the span is cut short
    if (raw_end > {1'b0, max_lines} + 11'h001) begin
      win_end = max_lines + 10'h001;
    end else begin
      win_end = raw_end[9:0];
    end
    if (win_end > {1'b0, st_q.first_line}) begin
      span = 9'(win_end - {1'b0, st_q.first_line});
    end else begin
      span = 9'h000;
    end
    // No interpolation: an output count above the span delivers the span
    out_eff = (st_q.output_lines > span) ? span : st_q.output_lines;
    horizontal_reference_rise = horizontal_reference_i && !st_q.horizontal_reference_prev;
    horizontal_reference_fall = !horizontal_reference_i && st_q.horizontal_reference_prev;
    vref_rise = vref_i && !st_q.vref_prev;
    line_next = st_q.line_no + 10'h001;
    in_window = (line_next >= {1'b0, st_q.first_line}) && (line_next < win_end);
    field_enable = st_q.field_odd ? !st_q.input_lines[vwvs_pkg::POS_FIELD_DIS_ODD]
                                  : !st_q.input_lines[vwvs_pkg::POS_FIELD_DIS_EVEN];
    line_acc_sum = {1'b0, st_q.line_acc} + {2'h0, out_eff};
    frame_sum = {1'b0, st_q.frame_acc} + {2'h0, st_q.kept_frames};
    keep_new = in_window && field_enable && (line_acc_sum >= {2'h0, span}) && (st_q.delivered < out_eff);
    // The first pixel comes with the reference edge, before line_keep is registered
    line_keep_now = vref_rise ? 1'b0 : (horizontal_reference_rise ? keep_new : st_q.line_keep);
    pix_active = pix_valid_i && horizontal_reference_i && line_keep_now && st_q.field_on && st_q.frame_keep;
  end

  always_comb begin
    st_d = st_q;
    st_d.horizontal_reference_prev = horizontal_reference_i;
    st_d.vref_prev = vref_i;

    // Bus write: address and data are taken independently
    if (s_axi_awvalid_i && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_idx = s_axi_awaddr_i[vwvs_pkg::ADDR_W-1:2];
      st_d.awready = 1'b0;
    end
    if (s_axi_wvalid_i && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata = s_axi_wdata_i[11:0];
      st_d.wstrb = s_axi_wstrb_i[1:0];
      st_d.wready = 1'b0;
    end
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = vwvs_pkg::RESP_OKAY;
      unique case (st_q.aw_idx)
        vwvs_pkg::IDX_WINDOW_FIRST_LINE: begin
          // Upper reserved bits are not stored and read as zero
          if (st_q.wstrb[0]) st_d.first_line[7:0] = st_q.wdata[7:0];
          if (st_q.wstrb[1]) st_d.first_line[8] = st_q.wdata[8];
        end
        vwvs_pkg::IDX_WINDOW_INPUT_LINES: begin
          if (st_q.wstrb[0]) st_d.input_lines[7:0] = st_q.wdata[7:0];
          if (st_q.wstrb[1]) st_d.input_lines[11:8] = st_q.wdata[11:8];
        end
        vwvs_pkg::IDX_WINDOW_OUTPUT_LINES: begin
          if (st_q.wstrb[0]) st_d.output_lines[7:0] = st_q.wdata[7:0];
          if (st_q.wstrb[1]) st_d.output_lines[8] = st_q.wdata[8];
        end
        vwvs_pkg::IDX_KEPT_FRAME_COUNT: begin
          if (st_q.wstrb[0]) st_d.kept_frames[7:0] = st_q.wdata[7:0];
          if (st_q.wstrb[1]) st_d.kept_frames[11:8] = st_q.wdata[11:8];
        end
        vwvs_pkg::IDX_LINE_STANDARD: begin
          if (st_q.wstrb[0]) st_d.std_525 = st_q.wdata[0];
        end
        vwvs_pkg::IDX_WINDOW_STATUS: begin
          // Writing a one to the overflow bit clears it
          if (st_q.wstrb[1] && st_q.wdata[vwvs_pkg::POS_STAT_OVF]) st_d.overflow = 1'b0;
        end
        vwvs_pkg::IDX_ACTIVE_FLAG_POSITION: begin
          st_d.bresp = vwvs_pkg::RESP_OKAY;
        end
        default: begin
          st_d.bresp = vwvs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && s_axi_bready_i) begin
      st_d.bvalid = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
    end

    // Bus read
    if (s_axi_arvalid_i && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp = vwvs_pkg::RESP_OKAY;
      st_d.rdata = 12'h000;
      unique case (s_axi_araddr_i[vwvs_pkg::ADDR_W-1:2])
        vwvs_pkg::IDX_ACTIVE_FLAG_POSITION: st_d.rdata = {st_q.active_offset, 1'b0};
        vwvs_pkg::IDX_WINDOW_FIRST_LINE: st_d.rdata = {3'h0, st_q.first_line};
        vwvs_pkg::IDX_WINDOW_INPUT_LINES: st_d.rdata = st_q.input_lines;
        vwvs_pkg::IDX_WINDOW_OUTPUT_LINES: st_d.rdata = {3'h0, st_q.output_lines};
        vwvs_pkg::IDX_KEPT_FRAME_COUNT: st_d.rdata = st_q.kept_frames;
        vwvs_pkg::IDX_LINE_STANDARD: st_d.rdata = {11'h000, st_q.std_525};
        vwvs_pkg::IDX_WINDOW_STATUS: st_d.rdata = {st_q.overflow, 2'h0, st_q.last_delivered};
        default: st_d.rresp = vwvs_pkg::RESP_SLVERR;
      endcase
    end
    if (st_q.rvalid && s_axi_rready_i) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end

    // Field start: restart line tracking and decide frame keep on odd fields
    if (vref_rise) begin
      st_d.field_odd = field_odd_i;
      st_d.line_no = 10'h000;
      st_d.line_acc = 10'h000;
      st_d.delivered = 9'h000;
      st_d.last_delivered = st_q.delivered;
      st_d.line_keep = 1'b0;
      st_d.sof_pend = 1'b1;
      st_d.field_on = field_odd_i ? !st_q.input_lines[vwvs_pkg::POS_FIELD_DIS_ODD]
                                  : !st_q.input_lines[vwvs_pkg::POS_FIELD_DIS_EVEN];
      if (field_odd_i) begin
        if (!st_q.input_lines[vwvs_pkg::POS_TDEC_EN]) begin
          st_d.frame_keep = 1'b1;
          st_d.frame_acc = 13'h0000;
        end else if (frame_sum >= {1'b0, vwvs_pkg::TDEC_INTERVAL}) begin
          // Kept frames are spread evenly over the 3000-frame interval
          st_d.frame_keep = 1'b1;
          st_d.frame_acc = 13'(frame_sum - {1'b0, vwvs_pkg::TDEC_INTERVAL});
        end else begin
          st_d.frame_keep = 1'b0;
          st_d.frame_acc = frame_sum[12:0];
        end
      end
    end else if (horizontal_reference_rise) begin
      st_d.line_no = line_next;
      st_d.line_keep = 1'b0;
      st_d.sol_pend = 1'b1;
      if (in_window && field_enable) begin
        // Bresenham step: keeps out of span lines, dropped ones interleaved
        if (keep_new) begin
          st_d.line_keep = 1'b1;
          st_d.line_acc = 10'(line_acc_sum - {2'h0, span});
          st_d.delivered = st_q.delivered + 9'h001;
        end else begin
          st_d.line_acc = line_acc_sum[9:0];
        end
      end
    end

    // Delay from the end of the reference pulse to the window's active flag
    if (horizontal_reference_fall) begin
      st_d.meas_cnt = 11'h000;
      st_d.meas_arm = 1'b1;
    end else if (st_q.meas_arm) begin
      if (pix_active) begin
        st_d.active_offset = st_q.meas_cnt;
        st_d.meas_arm = 1'b0;
      end else if (st_q.meas_cnt != 11'h7FF) begin
        st_d.meas_cnt = st_q.meas_cnt + 11'h001;
      end
    end

    // Pixels of kept lines go to the FIFO; a full FIFO drops them and flags it
    st_d.active = pix_active;
    st_d.push = 1'b0;
    if (st_q.push && !fifo_in.ready) begin
      st_d.overflow = 1'b1;
    end
    if (pix_active) begin
      st_d.push = 1'b1;
      st_d.push_data = {st_q.sof_pend, st_q.sol_pend || horizontal_reference_rise, pix_i};
      st_d.sol_pend = 1'b0;
      st_d.sof_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
      st_q.first_line <= vwvs_pkg::RST_FIRST_LINE;
      st_q.input_lines <= vwvs_pkg::RST_INPUT_LINES;
      st_q.output_lines <= vwvs_pkg::RST_OUTPUT_LINES;
      st_q.kept_frames <= vwvs_pkg::RST_KEPT_FRAMES;
      st_q.frame_keep <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : vwvs_top

// [hw/vwvs_pkg.sv]
// Constants for the second-window vertical select stage
package vwvs_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PIX_W = 16;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_ACTIVE_FLAG_POSITION = 10'h11F;
  localparam logic [9:0] IDX_WINDOW_FIRST_LINE = 10'h12A;
  localparam logic [9:0] IDX_WINDOW_INPUT_LINES = 10'h12B;
  localparam logic [9:0] IDX_WINDOW_OUTPUT_LINES = 10'h12C;
  localparam logic [9:0] IDX_KEPT_FRAME_COUNT = 10'h157;
  localparam logic [9:0] IDX_WINDOW_STATUS = 10'h160;
  localparam logic [9:0] IDX_LINE_STANDARD = 10'h161;
  // Reset values
  localparam logic [8:0] RST_FIRST_LINE = 9'h011;
  localparam logic [11:0] RST_INPUT_LINES = 12'h1F4;
  localparam logic [8:0] RST_OUTPUT_LINES = 9'h0F0;
  localparam logic [11:0] RST_KEPT_FRAMES = 12'hBB8;
  // Field positions in window_input_lines
  localparam int unsigned POS_TDEC_EN = 9;
  localparam int unsigned POS_FIELD_DIS_EVEN = 11;
  localparam int unsigned POS_FIELD_DIS_ODD = 10;
  // Field positions in window_status
  localparam int unsigned POS_STAT_OVF = 11;
  // Lines per field for each standard
  localparam logic [9:0] MAX_LINES_625 = 10'h139;
  localparam logic [9:0] MAX_LINES_525 = 10'h107;
  // Temporal decimation interval in frames
  localparam logic [12:0] TDEC_INTERVAL = 13'hBB8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vwvs_pkg

// [hw/vwvs_stream_if.sv]
// Valid/ready stream carrier between the window stage and its FIFO
`timescale 1ns/10ps
interface vwvs_stream_if #(
  parameter int unsigned WIDTH = 18
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : vwvs_stream_if

// [hw/vwvs_fifo.sv]
// Small FIFO with a registered output stage
`timescale 1ns/10ps
module vwvs_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  vwvs_stream_if.snk wr,
  vwvs_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("vwvs_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
  } vwvs_fifo_s;

  vwvs_fifo_s st_q;
  vwvs_fifo_s st_d;
  logic push;
  logic pop;

  // Storage full means the source must stall; output stage adds one slot
  assign wr.ready = (st_q.count != (AW + 1)'(DEPTH));
  assign rd.valid = st_q.out_valid;
  assign rd.data = st_q.out_data;
  assign push = wr.valid && wr.ready;
  assign pop = (st_q.count != '0) && (!st_q.out_valid || rd.ready);

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr_ptr] = wr.data;
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (rd.ready && st_q.out_valid) begin
      st_d.out_valid = 1'b0;
    end
    if (pop) begin
      st_d.out_data = st_q.mem[st_q.rd_ptr];
      st_d.out_valid = 1'b1;
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end
    st_d.count = st_q.count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : vwvs_fifo

// [bench/vwvs_checker.sv]
// Property checker for the window select stage, bound to its top
`timescale 1ns/10ps
module vwvs_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic horizontal_reference_i,
  input wire logic vref_i,
  input wire logic field_odd_i,
  input wire logic win_active_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic out_sol_o,
  input wire logic out_sof_o
);
  logic [9:0] aw_q, ar_q, ln_q;
  logic [11:0] wd_q, first_q, inl_q, out_q;
  logic [8:0] sc_q;
  logic std_q, odd_q, h_q, v_q;
  always_ff @(posedge clk_i) begin
    h_q <= horizontal_reference_i;
    v_q <= vref_i;
    if (s_axi_awvalid_i && s_axi_awready_o) aw_q <= s_axi_awaddr_i[11:2];
    if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i[11:0];
    if (s_axi_arvalid_i && s_axi_arready_o) ar_q <= s_axi_araddr_i[11:2];
    if (vref_i && !v_q) odd_q <= field_odd_i;
  end
  // Shadows commit on the response, after the design has taken the word
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_q <= 12'h011;
      inl_q <= 12'h1F4;
      out_q <= 12'h0F0;
      std_q <= 1'b0;
      ln_q <= '0;
      sc_q <= '0;
    end else begin
      if (vref_i && !v_q) ln_q <= '0;
      else if (horizontal_reference_i && !h_q) ln_q <= ln_q + 10'h001;
      if (vref_i && !v_q) sc_q <= '0;
      else if (out_valid_o && out_ready_i && out_sol_o) sc_q <= sc_q + 9'h001;
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        if (aw_q == vwvs_pkg::IDX_WINDOW_FIRST_LINE) first_q <= wd_q;
        if (aw_q == vwvs_pkg::IDX_WINDOW_INPUT_LINES) inl_q <= wd_q;
        if (aw_q == vwvs_pkg::IDX_WINDOW_OUTPUT_LINES) out_q <= wd_q;
        if (aw_q == vwvs_pkg::IDX_LINE_STANDARD) std_q <= wd_q[0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_pos; s_axi_rvalid_o && ar_q == vwvs_pkg::IDX_ACTIVE_FLAG_POSITION
    |-> s_axi_rdata_o[0] == 1'b0 && s_axi_rdata_o[31:12] == 20'h0; endproperty
  a_pos: assert property (p_pos) else $error("flag position word malformed");
  property p_first; win_active_o |-> ln_q >= first_q[8:0]; endproperty
  a_first: assert property (p_first) else $error("active before first line");
  property p_span; win_active_o |-> h_q && ln_q < first_q[8:0] + inl_q[8:0]; endproperty
  a_span: assert property (p_span) else $error("active beyond span");
  property p_max; win_active_o |-> ln_q <= (std_q ? vwvs_pkg::MAX_LINES_525 : vwvs_pkg::MAX_LINES_625); endproperty
  a_max: assert property (p_max) else $error("active beyond standard");
  property p_fld; win_active_o |-> !(odd_q ? inl_q[10] : inl_q[11]); endproperty
  a_fld: assert property (p_fld) else $error("active in disabled field");
  // Checked at each taken line start, so a later lower output count does not trip on the old field's total
  property p_cnt; out_valid_o && out_ready_i && out_sol_o |-> sc_q < out_q[8:0]; endproperty
  a_cnt: assert property (p_cnt) else $error("too many lines in field");
  property p_sof; out_valid_o && out_sof_o |-> out_sol_o; endproperty
  a_sof: assert property (p_sof) else $error("field start off a line start");
  property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_sol_o); endproperty
  a_hold: assert property (p_hold) else $error("stalled output dropped");
endmodule : vwvs_checker
bind vwvs_top vwvs_checker vwvs_checker_i (.*);

// [bench/vwvs_capture.sv]
// Downstream capture model: takes the windowed stream and reports line starts
`timescale 1ns/10ps
module vwvs_capture (
  input wire logic stall_i,
  input wire logic out_valid_i,
  input wire logic [15:0] out_pix_i,
  input wire logic out_sol_i,
  output logic out_ready_o,
  output logic took_o,
  output logic [15:0] line_o
);
  // Back-pressure only when the bench commands it
  assign out_ready_o = !stall_i;
  assign took_o = out_valid_i && !stall_i && out_sol_i;
  assign line_o = out_pix_i;
endmodule : vwvs_capture

// [bench/tb_top.sv]
// Self-checking bench for the window select stage
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_arvalid_i = 0, s_axi_bready_i = 1, s_axi_rready_i = 1;
  logic horizontal_reference_i = 0, vref_i = 0, field_odd_i = 0, pix_valid_i = 0, stall = 0, hold = 0;
  logic [15:0] pix_i = '0, line, out_pix_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, took;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic win_active_o, out_valid_o, out_ready_i, out_sol_o, out_sof_o;
  int miscompares = 0, samples_checked = 0, cyc = 0, first = 17, inl = 500, outl = 240, mx = 313, n;
  logic [2:0] fl = '0;
  logic [15:0] got[$];
  logic [33:0] r;
  vwvs_top #(.FIFO_DEPTH(8)) vwvs_top_i (.*);
  vwvs_capture vwvs_capture_i (.stall_i(stall), .out_valid_i(out_valid_o), .out_pix_i(out_pix_o),
    .out_sol_i(out_sol_o), .out_ready_o(out_ready_i), .took_o(took), .line_o(line));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (took) got.push_back(line);
    if (cyc == 90000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk_reg(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: register got %h expected %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_line(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: line got %h expected %h", $time, g, e);
    end
  endtask : chk_line
  task automatic wr(input logic [9:0] idx, input logic [11:0] d, input logic [1:0] er);
    s_axi_awaddr_i <= {idx, 2'h0};
    s_axi_wdata_i <= {20'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    chk_reg({32'h0, s_axi_bresp_o}, {32'h0, er});
  endtask : wr
  task automatic rd(input logic [9:0] idx);
    s_axi_araddr_i <= {idx, 2'h0};
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    r = {s_axi_rresp_o, s_axi_rdata_o};
  endtask : rd
  // Random stalls are light enough that the FIFO never overflows
  task automatic tick(input int k);
    repeat (k) begin
      stall <= hold | ($urandom_range(3) == 0);
      @(posedge clk_i);
    end
  endtask : tick
  task automatic field(input logic odd);
    vref_i <= 1'b1;
    field_odd_i <= odd;
    tick(1);
    vref_i <= 1'b0;
    tick(4);
    for (int l = 1; l <= mx; l++) begin
      horizontal_reference_i <= 1'b1;
      pix_valid_i <= 1'b1;
      pix_i <= 16'(l);
      tick(4);
      horizontal_reference_i <= 1'b0;
      pix_valid_i <= 1'b0;
      tick(4);
    end
    tick(40);
  endtask : field
  task automatic setw(input int f, input int k, input int o, input logic [2:0] flags);
    first = f;
    inl = k;
    outl = o;
    fl = flags;
    wr(vwvs_pkg::IDX_WINDOW_FIRST_LINE, 12'(f), vwvs_pkg::RESP_OKAY);
    wr(vwvs_pkg::IDX_WINDOW_INPUT_LINES, {flags, 9'(k)}, vwvs_pkg::RESP_OKAY);
    wr(vwvs_pkg::IDX_WINDOW_OUTPUT_LINES, 12'(o), vwvs_pkg::RESP_OKAY);
  endtask : setw
  task automatic run(input logic odd, input logic on);
    int sp, oe;
    int acc = 0;
    logic [15:0] ex[$];
    sp = (first + inl > mx + 1) ? mx + 1 - first : inl;
    oe = (outl > sp) ? sp : outl;
    if (on && !fl[odd ? 1 : 2])
      for (int l = first; l < first + sp; l++) begin
        acc += oe;
        if (acc >= sp) begin
          acc -= sp;
          ex.push_back(16'(l));
        end
      end
    got.delete();
    field(odd);
    chk_line(16'(got.size()), 16'(ex.size()));
    foreach (ex[i]) if (i < got.size()) chk_line(got[i], ex[i]);
  endtask : run
  initial begin
    void'($urandom(32'hAE1D));
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(vwvs_pkg::IDX_WINDOW_FIRST_LINE);
    chk_reg(r, 34'h011);
    rd(vwvs_pkg::IDX_WINDOW_INPUT_LINES);
    chk_reg(r, 34'h1F4);
    rd(vwvs_pkg::IDX_WINDOW_OUTPUT_LINES);
    chk_reg(r, 34'h0F0);
    rd(vwvs_pkg::IDX_KEPT_FRAME_COUNT);
    chk_reg(r, 34'hBB8);
    rd(10'h100);
    chk_reg(r, {vwvs_pkg::RESP_SLVERR, 32'h0});
    wr(10'h100, 12'h5A5, vwvs_pkg::RESP_SLVERR);
    wr(vwvs_pkg::IDX_ACTIVE_FLAG_POSITION, 12'hFFF, vwvs_pkg::RESP_OKAY);
    run(1'b1, 1'b1);
    run(1'b0, 1'b1);
    rd(vwvs_pkg::IDX_ACTIVE_FLAG_POSITION);
    // Four idle reference cycles between lines put the first kept pixel at offset three
    chk_reg(r, 34'h006);
    for (int k = 0; k < 2; k++) begin
      n = $urandom_range(200, 20);
      setw($urandom_range(40, 7), n, $urandom_range(n, 1), 3'h0);
      run(1'b1, 1'b1);
      run(1'b0, 1'b1);
    end
    for (int c = 0; c < 4; c++) begin
      setw(20, 30, 30, 3'(c << 1));
      run(1'b1, 1'b1);
      run(1'b0, 1'b1);
    end
    wr(vwvs_pkg::IDX_KEPT_FRAME_COUNT, 12'h000, vwvs_pkg::RESP_OKAY);
    setw(20, 30, 10, 3'h1);
    run(1'b1, 1'b0);
    run(1'b0, 1'b0);
    wr(vwvs_pkg::IDX_KEPT_FRAME_COUNT, 12'hBB8, vwvs_pkg::RESP_OKAY);
    run(1'b1, 1'b1);
    wr(vwvs_pkg::IDX_KEPT_FRAME_COUNT, 12'h000, vwvs_pkg::RESP_OKAY);
    setw(20, 30, 10, 3'h0);
    run(1'b1, 1'b1);
    wr(vwvs_pkg::IDX_LINE_STANDARD, 12'h001, vwvs_pkg::RESP_OKAY);
    mx = 263;
    setw(250, 100, 100, 3'h0);
    run(1'b1, 1'b1);
    // A field with the sink stalled throughout must overflow the FIFO
    hold = 1'b1;
    field(1'b1);
    hold = 1'b0;
    tick(40);
    chk_line({15'h0, out_valid_o}, 16'h0000);
    rd(vwvs_pkg::IDX_WINDOW_STATUS);
    chk_reg(r & 34'h800, 34'h800);
    wr(vwvs_pkg::IDX_WINDOW_STATUS, 12'h800, vwvs_pkg::RESP_OKAY);
    rd(vwvs_pkg::IDX_WINDOW_STATUS);
    chk_reg(r & 34'h800, 34'h0);
    complete_run();
  end
endmodule : tb_top
